// ### design/irq_async_latch.sv
`timescale 1ns/100ps
`default_nettype none
module irq_async_latch (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    input  wire logic irq_n_i,
    input  wire logic clr_i,
    output logic      wake_o
);
    logic hit_q;
    logic hit_s;
    logic hit_ns;
    wire  latch_rst_n = nrst_i & ~clr_i;

    // Falling pin sets the latch with no clock running; the clear empties it.
    always_ff @(negedge irq_n_i or negedge latch_rst_n)
    begin
        if (!latch_rst_n)
            hit_q <= 1'b0;
        else
            hit_q <= 1'b1;
    end

    // Passed inverted so the synchroniser's reset value reads as no hit.
    sync2 #(.W(1)) u_sync (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .d_i    (~hit_q),
        .q_o    (hit_ns)
    );

    assign hit_s = ~hit_ns;

    // Acknowledge arrives in clock domain; held as a sticky flag.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wake_o <= 1'b0;
        else if (hit_s)
            wake_o <= 1'b1;
        else if (clr_i)
            wake_o <= 1'b0;
    end
endmodule
`default_nettype wire

// ### design/reset_irq_pin_control.sv
// Summary of operation
// - Timer pins reset to timer function
// - Per-pin pull-up bit; clear removes pull-up
// - Interrupts caught asynchronously in stop/wait
// - Interrupts synchronised in other modes
// - Each interrupt level or falling-edge triggered
// - One bit disables both interrupt pull-ups
// - Reset low holds device in reset
// - Boot select captured at reset release
// - Internal reset held fixed cycles, synchronous release
// - Device reset alone leaves debug logic intact
// - Power-on reset asserts internal reset
// - Reset pull-up disable bit removes pull-up
// - Reset output follows internal reset
// - Boot high and unsecured means external boot
`timescale 1ns/100ps
`default_nettype none
module reset_irq_pin_control #(
    parameter int HOLD_CYCLES = rst_pin_pkg::RST_HOLD_CYCLES
) (
    // Clock and power-on reset.
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Board pins.
    input  wire logic        reset_pin_n_i,
    input  wire logic        boot_select_pin_i,
    input  wire logic        ext_irq_a_n_i,
    input  wire logic        ext_irq_b_n_i,
    input  wire logic        flash_secure_i,
    // Register port.
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Reset and mode outputs.
    output logic             core_rst_n_o,
    output logic             reset_out_pin_n_o,
    output logic             ext_boot_o,
    // Interrupt requests.
    output logic             irq_a_req_o,
    output logic             irq_b_req_o,
    // Pin function and pull-ups.
    output logic      [3:0]  timer_d_gpio_sel_o,
    output logic      [3:0]  timer_d_pullup_o,
    output logic             irq_pullup_o,
    output logic             reset_pullup_o
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin synchroniser and sequencer.
    logic             rst_pin_s;
    logic             boot_s;
    logic             rst_asrt_s;
    logic             boot_low_s;
    rst_pin_pkg::rst_state_e state_q;
    rst_pin_pkg::rst_state_e state_d;
    logic [CW-1:0]    cnt_q;
    logic             boot_q;
    logic             in_rst;

    // Pins pass inverted so the synchroniser's reset value reads as reset asserted.
    sync2 #(.W(2)) u_rst_sync (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .d_i    ({~reset_pin_n_i, ~boot_select_pin_i}),
        .q_o    ({rst_asrt_s, boot_low_s})
    );

    assign rst_pin_s = ~rst_asrt_s;
    assign boot_s    = ~boot_low_s;

    wire cnt_done = (cnt_q == CW'(HOLD_CYCLES - 1));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rst_pin_pkg::ST_RESET: if (rst_pin_s) state_d = rst_pin_pkg::ST_HOLD;
            rst_pin_pkg::ST_HOLD:  if (!rst_pin_s) state_d = rst_pin_pkg::ST_RESET;
                                   else if (cnt_done) state_d = rst_pin_pkg::ST_RUN;
            rst_pin_pkg::ST_RUN:   if (!rst_pin_s) state_d = rst_pin_pkg::ST_RESET;
            default:               state_d = rst_pin_pkg::ST_RESET;
        endcase
    end

    // Power-on reset starts in reset state regardless of the pin.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= rst_pin_pkg::ST_RESET;
            cnt_q   <= '0;
            boot_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (state_q == rst_pin_pkg::ST_HOLD) ? cnt_q + CW'(1) : '0;
            if (state_q == rst_pin_pkg::ST_RESET && rst_pin_s)
                boot_q <= boot_s;
        end
    end

    assign in_rst = (state_q != rst_pin_pkg::ST_RUN);

    // Only the core reset and the reset output are driven; test/debug reset is separate.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            core_rst_n_o      <= 1'b0;
            reset_out_pin_n_o <= 1'b0;
            ext_boot_o        <= 1'b0;
        end
        else
        begin
            core_rst_n_o      <= (state_d == rst_pin_pkg::ST_RUN);
            reset_out_pin_n_o <= (state_d == rst_pin_pkg::ST_RUN);
            ext_boot_o        <= boot_q & ~flash_secure_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [3:0] pin_func_q;
    logic [3:0] port_pur_q;
    logic [1:0] sys_pudr_q;
    logic [1:0] irq_ctrl_q;
    logic       lp_mode_q;
    logic       wake_a;
    logic       wake_b;

    wire wr_func = wr_i && addr_i == rst_pin_pkg::OFS_PIN_FUNC;
    wire wr_pur  = wr_i && addr_i == rst_pin_pkg::OFS_PORT_PUR;
    wire wr_pudr = wr_i && addr_i == rst_pin_pkg::OFS_SYS_PUDR;
    wire wr_ictl = wr_i && addr_i == rst_pin_pkg::OFS_IRQ_CTRL;
    wire wr_lp   = wr_i && addr_i == rst_pin_pkg::OFS_LP_MODE;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_func_q <= rst_pin_pkg::PIN_FUNC_RST;
            port_pur_q <= rst_pin_pkg::PORT_PUR_RST;
            sys_pudr_q <= rst_pin_pkg::SYS_PUDR_RST;
            irq_ctrl_q <= rst_pin_pkg::IRQ_CTRL_RST;
            lp_mode_q  <= 1'b0;
        end
        else if (in_rst)
        begin
            pin_func_q <= rst_pin_pkg::PIN_FUNC_RST;
            port_pur_q <= rst_pin_pkg::PORT_PUR_RST;
            sys_pudr_q <= rst_pin_pkg::SYS_PUDR_RST;
            irq_ctrl_q <= rst_pin_pkg::IRQ_CTRL_RST;
            lp_mode_q  <= 1'b0;
        end
        else
        begin
            if (wr_func) pin_func_q <= wdata_i[3:0];
            if (wr_pur)  port_pur_q <= wdata_i[3:0];
            if (wr_pudr) sys_pudr_q <= wdata_i[1:0];
            if (wr_ictl) irq_ctrl_q <= wdata_i[1:0];
            if (wr_lp)   lp_mode_q  <= wdata_i[0];
        end
    end

    wire [31:0] status_w = {28'h0, irq_b_req_o, irq_a_req_o, boot_q & ~flash_secure_i, boot_q};

    wire [31:0] rd_mux =
        (addr_i == rst_pin_pkg::OFS_PIN_FUNC) ? {28'h0, pin_func_q} :
        (addr_i == rst_pin_pkg::OFS_PORT_PUR) ? {28'h0, port_pur_q} :
        (addr_i == rst_pin_pkg::OFS_SYS_PUDR) ? {30'h0, sys_pudr_q} :
        (addr_i == rst_pin_pkg::OFS_IRQ_CTRL) ? {30'h0, irq_ctrl_q} :
        (addr_i == rst_pin_pkg::OFS_STATUS)   ? status_w :
        (addr_i == rst_pin_pkg::OFS_LP_MODE)  ? {31'h0, lp_mode_q} : 32'h0;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o            <= 32'h0;
            timer_d_gpio_sel_o <= 4'h0;
            timer_d_pullup_o   <= 4'hf;
            irq_pullup_o       <= 1'b1;
            reset_pullup_o     <= 1'b1;
        end
        else
        begin
            rdata_o            <= rd_i ? rd_mux : 32'h0;
            timer_d_gpio_sel_o <= pin_func_q;
            timer_d_pullup_o   <= port_pur_q;
            irq_pullup_o       <= ~sys_pudr_q[rst_pin_pkg::PUDR_IRQ_BIT];
            reset_pullup_o     <= ~sys_pudr_q[rst_pin_pkg::PUDR_RESET_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External interrupts.
    logic [1:0] irq_s;
    logic [1:0] irq_prev_q;
    logic [1:0] irq_req;

    sync2 #(.W(2)) u_irq_sync (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .d_i    ({ext_irq_b_n_i, ext_irq_a_n_i}),
        .q_o    (irq_s)
    );

    irq_async_latch u_wake_a (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .irq_n_i (ext_irq_a_n_i),
        .clr_i   (~lp_mode_q),
        .wake_o  (wake_a)
    );

    irq_async_latch u_wake_b (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .irq_n_i (ext_irq_b_n_i),
        .clr_i   (~lp_mode_q),
        .wake_o  (wake_b)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_irq
            // Edge mode: previous high, now low; level mode: low.
            assign irq_req[g] = irq_ctrl_q[g] ? (irq_prev_q[g] & ~irq_s[g]) : ~irq_s[g];
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            irq_prev_q  <= 2'h3;
            irq_a_req_o <= 1'b0;
            irq_b_req_o <= 1'b0;
        end
        else
        begin
            irq_prev_q  <= irq_s;
            irq_a_req_o <= ~in_rst & (irq_req[0] | (lp_mode_q & wake_a));
            irq_b_req_o <= ~in_rst & (irq_req[1] | (lp_mode_q & wake_b));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    a_rstout_follows: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        reset_out_pin_n_o == core_rst_n_o)
        else $error("reset output differs from internal reset");

    a_pin_low_holds: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !rst_pin_s |=> !core_rst_n_o)
        else $error("core left reset with pin low");

    a_hold_count: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(core_rst_n_o) |-> $past(state_q) == rst_pin_pkg::ST_HOLD && $past(cnt_done))
        else $error("reset released before hold count");

    a_boot_latch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q == rst_pin_pkg::ST_RESET && rst_pin_s) |=> boot_q == $past(boot_s))
        else $error("boot select not captured");

    a_func_reset: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        in_rst |=> pin_func_q == rst_pin_pkg::PIN_FUNC_RST)
        else $error("timer pins not timer after reset");

    a_irq_pullup: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        irq_pullup_o == ~$past(sys_pudr_q[rst_pin_pkg::PUDR_IRQ_BIT]))
        else $error("irq pull-up wrong");

    a_rst_pullup: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        reset_pullup_o == ~$past(sys_pudr_q[rst_pin_pkg::PUDR_RESET_BIT]))
        else $error("reset pull-up wrong");

    a_edge_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (irq_ctrl_q[0] && !lp_mode_q && !in_rst && irq_s[0] == 1'b0 && irq_prev_q[0] == 1'b0
         && $stable(irq_ctrl_q)) |=> !irq_a_req_o)
        else $error("edge mode request without edge");

    a_lp_wake: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (lp_mode_q && wake_b && !in_rst) |=> irq_b_req_o)
        else $error("low-power wake not raised");

    a_no_req_rst: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        in_rst |=> !irq_a_req_o && !irq_b_req_o)
        else $error("request raised during reset");

    a_gpio_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        timer_d_gpio_sel_o == $past(pin_func_q))
        else $error("pin function output wrong");

    a_pullup_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        timer_d_pullup_o == $past(port_pur_q))
        else $error("port pull-up output wrong");

    a_ext_boot: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ext_boot_o == $past(boot_q & ~flash_secure_i))
        else $error("external boot output wrong");

    a_rst_core_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q == rst_pin_pkg::ST_HOLD && !cnt_done) |=> !core_rst_n_o)
        else $error("core left reset before count");
endmodule
`default_nettype wire

// ### design/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // Two flip-flops; the first feeds only the second.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= '1;
            q_o    <= '1;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### shared/rst_pin_pkg.sv
`default_nettype none
package rst_pin_pkg;
    // Register map, word offsets as byte addresses.
    localparam logic [7:0] OFS_PIN_FUNC   = 8'h00;
    localparam logic [7:0] OFS_PORT_PUR   = 8'h04;
    localparam logic [7:0] OFS_SYS_PUDR   = 8'h08;
    localparam logic [7:0] OFS_IRQ_CTRL   = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_LP_MODE    = 8'h14;
    // System pull-up disable fields.
    localparam int PUDR_IRQ_BIT   = 0;
    localparam int PUDR_RESET_BIT = 1;
    // Interrupt control fields.
    localparam int IRQ_EDGE_A_BIT = 0;
    localparam int IRQ_EDGE_B_BIT = 1;
    // Status fields.
    localparam int STAT_BOOT_BIT  = 0;
    localparam int STAT_EXT_BIT   = 1;
    localparam int STAT_EXT_IRQ_A_BIT  = 2;
    localparam int STAT_EXT_IRQ_B_BIT  = 3;
    // Reset values.
    localparam logic [3:0] PIN_FUNC_RST  = 4'h0;
    localparam logic [3:0] PORT_PUR_RST  = 4'hf;
    localparam logic [1:0] SYS_PUDR_RST  = 2'h0;
    localparam logic [1:0] IRQ_CTRL_RST  = 2'h0;
    // Internal reset stretch.
    localparam int RST_HOLD_CYCLES = 32;
    localparam int CLK_PERIOD_NS   = 10;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_HOLD  = 2'b01,
        ST_RUN   = 2'b10
    } rst_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;
endpackage
`default_nettype wire

// ### tb/board_model.sv
`timescale 1ns/100ps
`default_nettype none
module board_model (
    // Requests from the bench.
    input  wire logic rst_req_i,
    input  wire logic full_rst_i,
    input  wire logic boot_i,
    input  wire logic irq_a_i,
    input  wire logic irq_b_i,
    // Board pins.
    output logic      reset_pin_n_o,
    output logic      boot_select_pin_o,
    output logic      ext_irq_a_n_o,
    output logic      ext_irq_b_n_o,
    output logic      trst_n_o
);
    // The reset line is pulled high whenever the board releases it.
    assign reset_pin_n_o     = !rst_req_i;
    assign trst_n_o          = !(rst_req_i && full_rst_i);
    assign boot_select_pin_o = boot_i;
    // Interrupt sources drive low to request and high otherwise.
    assign ext_irq_a_n_o     = !irq_a_i;
    assign ext_irq_b_n_o     = !irq_b_i;
endmodule
`default_nettype wire

// ### tb/reset_irq_pin_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_irq_pin_control_tb;
    localparam int H = 4;
    logic        mclk_i, nrst_i, rst_req, full_rst, boot, irq_a, irq_b, sec;
    logic        rst_pin_n, boot_pin, irq_a_n, irq_b_n, trst_n;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic        wr_i, rd_i, core_n, rst_out_n, ext_boot, req_a, req_b;
    logic [3:0]  sel, pur;
    logic        irq_pu, rst_pu;
    int          n_errors, total_checks, n;

    board_model i_board (.rst_req_i(rst_req), .full_rst_i(full_rst), .boot_i(boot),
        .irq_a_i(irq_a), .irq_b_i(irq_b), .reset_pin_n_o(rst_pin_n),
        .boot_select_pin_o(boot_pin), .ext_irq_a_n_o(irq_a_n), .ext_irq_b_n_o(irq_b_n),
        .trst_n_o(trst_n));
    reset_irq_pin_control #(.HOLD_CYCLES(H)) i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .reset_pin_n_i(rst_pin_n), .boot_select_pin_i(boot_pin), .ext_irq_a_n_i(irq_a_n),
        .ext_irq_b_n_i(irq_b_n), .flash_secure_i(sec), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_rst_n_o(core_n),
        .reset_out_pin_n_o(rst_out_n), .ext_boot_o(ext_boot), .irq_a_req_o(req_a),
        .irq_b_req_o(req_b), .timer_d_gpio_sel_o(sel), .timer_d_pullup_o(pur),
        .irq_pullup_o(irq_pu), .reset_pullup_o(rst_pu));

    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    // Pulses the board reset with the given boot level and times the release.
    task automatic pin_reset(input logic b);
        @(posedge mclk_i);
        rst_req <= 1'b1;
        boot    <= b;
        cyc(6);
        chk("core_rst_n", 0, core_n);
        wr(rst_pin_pkg::OFS_PIN_FUNC, 32'h0000000f);
        @(posedge mclk_i);
        rst_req <= 1'b0;
        n = 0;
        #1;
        while (core_n !== 1'b1 && n < 40)
        begin
            chk("reset_out", core_n, rst_out_n);
            cyc(1);
            n++;
        end
        chk("hold_count", 1, n >= H && n <= H + 4);
        chk("reset_out", core_n, rst_out_n);
        rd(rst_pin_pkg::OFS_PIN_FUNC, d);
        chk("pin_func", 0, d);
    endtask

    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #200us;
        n_errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors = 0;
        total_checks = 0;
        nrst_i = 1'b0;
        {rst_req, full_rst, boot, irq_a, irq_b, sec} = 6'h30;
        {addr_i, wdata_i, wr_i, rd_i} = '0;
        cyc(6);
        chk("core_rst_n", 0, core_n);
        chk("trst_n", 0, trst_n);
        nrst_i <= 1'b1;
        full_rst <= 1'b0;
        pin_reset(1'b1);
        chk("trst_n", 1, trst_n);
        chk("ext_boot", 1, ext_boot);
        chk("gpio_sel", 0, sel);
        chk("pullups", 32'h7f, {pur, irq_pu, rst_pu, 1'b1});
        rd(rst_pin_pkg::OFS_STATUS, d);
        chk("status_boot", 1, d[rst_pin_pkg::STAT_BOOT_BIT]);
        chk("status_ext", 1, d[rst_pin_pkg::STAT_EXT_BIT]);
        rd(8'hfc, d);
        chk("unmapped", 0, d);
        wr(rst_pin_pkg::OFS_PIN_FUNC, 32'h0000000a);
        wr(rst_pin_pkg::OFS_PORT_PUR, 32'h00000005);
        wr(rst_pin_pkg::OFS_SYS_PUDR, 32'h00000001);
        cyc(2);
        chk("gpio_sel", 4'ha, sel);
        chk("pullups", 4'h5, pur);
        chk("irq_pullup", 0, irq_pu);
        chk("reset_pullup", 1, rst_pu);
        wr(rst_pin_pkg::OFS_SYS_PUDR, 32'h00000002);
        cyc(2);
        chk("irq_pullup", 1, irq_pu);
        chk("reset_pullup", 0, rst_pu);
        // Level mode then falling-edge mode on inputs A and B.
        for (int m = 0; m < 2; m++)
        begin
            wr(rst_pin_pkg::OFS_IRQ_CTRL, m * 3);
            cyc(4);
            chk("irq_a_idle", 0, req_a);
            chk("irq_b_idle", 0, req_b);
            @(posedge mclk_i);
            irq_a <= 1'b1;
            irq_b <= 1'b1;
            cyc(1);
            chk("irq_a_sync", 0, req_a);
            n = 0;
            while (req_a !== 1'b1 && n < 6)
            begin
                cyc(1);
                n++;
            end
            chk("irq_a_req", 1, req_a);
            chk("irq_b_req", 1, req_b);
            cyc(8);
            chk("irq_a_level", (m == 0), req_a);
            chk("irq_b_level", (m == 0), req_b);
            @(posedge mclk_i);
            irq_a <= 1'b0;
            irq_b <= 1'b0;
            cyc(6);
            chk("irq_a_clear", 0, req_a);
            chk("irq_b_clear", 0, req_b);
        end
        // Low-power mode: a glitch between edges must still be caught.
        wr(rst_pin_pkg::OFS_LP_MODE, 32'h00000001);
        @(posedge mclk_i);
        #2 irq_b <= 1'b1;
        #2 irq_b <= 1'b0;
        n = 0;
        while (req_b !== 1'b1 && n < 6)
        begin
            cyc(1);
            n++;
        end
        chk("irq_b_wake", 1, req_b);
        chk("irq_a_quiet", 0, req_a);
        rd(rst_pin_pkg::OFS_STATUS, d);
        chk("status_ext_irq_b", 1, d[rst_pin_pkg::STAT_EXT_IRQ_B_BIT]);
        wr(rst_pin_pkg::OFS_LP_MODE, 32'h00000000);
        cyc(6);
        chk("irq_b_clear", 0, req_b);
        sec <= 1'b1;
        pin_reset(1'b1);
        chk("ext_boot", 0, ext_boot);
        chk("pullups", 32'h7f, {pur, irq_pu, rst_pu, 1'b1});
        sec <= 1'b0;
        pin_reset(1'b0);
        chk("ext_boot", 0, ext_boot);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        #2 chk("core_rst_n", 0, core_n);
        chk("reset_out", 0, rst_out_n);
        end_sim();
    end
endmodule
`default_nettype wire
